// [pkg/flash_cmd_pkg.sv]
/*
 * constants for the flash command logic: opcodes, phase lengths,
 * wrap layout and reset value, program timing.
 * assumes a 125 MHz core clock that oversamples the serial clock.
 */
package flash_cmd_pkg;

    // opcodes handled by this block
    localparam logic [7:0] OP_OCTAL_WORD_READ = 8'hE3;
    localparam logic [7:0] OP_SET_WRAP        = 8'h77;
    localparam logic [7:0] OP_PAGE_PROGRAM    = 8'h02;

    // phase lengths and per-clock steps in bits
    localparam logic [5:0] OPCODE_BITS  = 6'h08;
    localparam logic [5:0] ADDR_BITS_3B = 6'h18;
    localparam logic [5:0] ADDR_BITS_4B = 6'h20;
    localparam logic [5:0] MODE_BITS    = 6'h08;
    localparam logic [5:0] WRAP_BITS    = 6'h08;
    localparam logic [5:0] DATA_BITS    = 6'h08;
    localparam logic [5:0] QUAD_STEP    = 6'h04;
    localparam logic [5:0] SERIAL_STEP  = 6'h01;

    // mode bits: key position and the code that skips the opcode
    localparam int         MODE_KEY_LSB  = 4;
    localparam logic [1:0] MODE_CONT_KEY = 2'h2;

    // wrap configuration: stored as {length field, disable bit}
    localparam int         WRAP_FIELD_LSB = 4;
    localparam int         WRAP_DIS_POS   = 0;
    localparam logic [2:0] WRAP_CFG_RST   = 3'h1;
    localparam logic [7:0] WRAP_MIN_MASK  = 8'h07;

    // page geometry
    localparam int         PAGE_IDX_W = 8;
    localparam logic [8:0] PAGE_BYTES = 9'h100;

    // self-timed program cycle
    localparam int PROG_TIME_US  = 700;
    localparam int MCLK_FREQ_MHZ = 125;
    localparam int PROG_CYCLES   = PROG_TIME_US * MCLK_FREQ_MHZ;

endpackage : flash_cmd_pkg

// [core/pin_sync.sv]
/*
 * two-flop synchroniser with edge pulses for a pin group.
 * assumes async pins slower than mclk / 4.
 */
`timescale 1ns/1ps
module pin_sync #(
    parameter int           W       = 6,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         rstn,
    // raw pins
    input  wire logic [W-1:0] pin_in,
    // synchronised level and edge pulses
    output logic      [W-1:0] level,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;
    logic [W-1:0] prev_ff;

    // only sync_ff reads meta_ff
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            meta_ff <= RST_VAL;
            sync_ff <= RST_VAL;
            prev_ff <= RST_VAL;
        end
        else
        begin
            meta_ff <= pin_in;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    // edges from the second and third stages
    assign level = sync_ff;
    assign rise  = sync_ff & ~prev_ff;
    assign fall  = ~sync_ff & prev_ff;

endmodule : pin_sync

// [core/prog_timer.sv]
/*
 * self-timed program cycle: busy until the count expires.
 * assumes start is a one-cycle pulse; starts while busy drop.
 */
`timescale 1ns/1ps
module prog_timer #(
    parameter int unsigned CYCLES = flash_cmd_pkg::PROG_CYCLES
) (
    // clock and reset
    input  wire logic mclk,
    input  wire logic rstn,
    // control
    input  wire logic start,
    output logic      busy,
    output logic      done
);
    localparam int CW = $clog2(CYCLES + 1);

    logic [CW-1:0] left_ff;
    logic          busy_ff;
    logic          done_ff;

    // count down the program time
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            left_ff <= '0;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
        end
        else
        begin
            done_ff <= 1'b0;
            if (start && !busy_ff)
            begin
                left_ff <= CW'(CYCLES - 1);
                busy_ff <= 1'b1;
            end
            else if (busy_ff && left_ff == '0)
            begin
                busy_ff <= 1'b0;
                done_ff <= 1'b1;
            end
            else if (busy_ff)
            begin
                left_ff <= left_ff - 1'b1;
            end
        end
    end

    assign busy = busy_ff;
    assign done = done_ff;

endmodule : prog_timer

// [core/quad_flash_cmd.sv]
/*
 * flash command logic: aligned quad read with continuous mode,
 * wrap setting and single-lane page program.
 * assumes host pins run at most at mclk / 4;
 * rd_data follows rd_addr by one mclk;
 * page_protected and the page buffer are same-clock logic.
 */
// Notes on behaviour
// - aligned read zeroes address bits 3:0, no dummies
// - aligned read needs the quad I/O enable bit unless started in continuous mode
// - mode bits follow address; bits 5:4 decide
// - mode bits 5:4 = 10: next frame starts at address
// - other mode values: next frame needs an opcode
// - wrap command: 77h, 24/32 dummy bits, wrap byte
// - disable bit zero wraps in 8/16/32/64 byte section
// - stored wrap setting holds for later quad reads
// - wrap disable bit is one after any reset
// - four-byte mode: 32 dummy bits, 32-bit address
// - page program 02h needs the write enable latch
// - program index wraps in page; later bytes overwrite
// - chip select rising mid-byte discards the program
// - program cycle holds busy one, clears it at end
// - write enable latch clears when program completes
// - protected target page is never programmed
`timescale 1ns/1ps
module quad_flash_cmd #(
    parameter int unsigned PROG_CYCLES = flash_cmd_pkg::PROG_CYCLES
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rstn,
    // serial pins
    input  wire logic        sclk_pin,
    input  wire logic        cs_n_pin,
    input  wire logic [3:0]  io_in,
    output logic      [3:0]  io_out,
    output logic      [3:0]  io_oe,
    // configuration and control
    input  wire logic        quad_io_enable_bit,
    input  wire logic        four_byte_mode,
    input  wire logic        soft_reset,
    input  wire logic        latch_set,
    input  wire logic        latch_clr,
    // array read port
    output logic      [31:0] rd_addr,
    input  wire logic [7:0]  rd_data,
    // page buffer write port
    output logic             buf_we,
    output logic      [7:0]  buf_idx,
    output logic      [7:0]  buf_data,
    // program request and status
    output logic      [31:0] prog_addr,
    input  wire logic        page_protected,
    output logic             prog_start,
    output logic             busy,
    output logic             write_enable_latch,
    output logic      [2:0]  wrap_config,
    output logic             continuous_read_mode
);
    typedef enum logic [3:0] {
        ST_IDLE, ST_OPCODE, ST_QADDR, ST_MODE, ST_RDATA,
        ST_WDUMMY, ST_WBITS, ST_PADDR, ST_PDATA, ST_IGNORE
    } phase_e;

    // next read address under the wrap setting
    function automatic logic [31:0] wrap_next(input logic [31:0] a, input logic [2:0] cfg);
        logic [7:0] mask;
        logic [7:0] low;
        mask = 8'h00;
        low  = 8'h00;
        if (cfg[flash_cmd_pkg::WRAP_DIS_POS])
        begin
            wrap_next = a + 32'h1;
        end
        else
        begin
            mask = (flash_cmd_pkg::WRAP_MIN_MASK << cfg[2:1]) | flash_cmd_pkg::WRAP_MIN_MASK;
            low  = a[7:0] + 8'h01;
            wrap_next = {a[31:8], (a[7:0] & ~mask) | (low & mask)};
        end
    endfunction : wrap_next

    logic [5:0]  pin_lvl;
    logic [5:0]  pin_rise;
    logic [5:0]  pin_fall;
    logic        tmr_busy;
    logic        tmr_done;

    phase_e      state_ff;
    logic [5:0]  cnt_ff;
    logic [31:0] shift_ff;
    logic [31:0] addr_ff;
    logic        nib_ff;
    logic        cont_mode_ff;
    logic [2:0]  wrap_cfg_ff;
    logic [7:0]  wr_idx_ff;
    logic [8:0]  nbytes_ff;
    logic [3:0]  io_out_ff;
    logic [3:0]  io_oe_ff;
    logic        buf_we_ff;
    logic [7:0]  buf_idx_ff;
    logic [7:0]  buf_data_ff;
    logic [31:0] prog_addr_ff;
    logic        prog_start_ff;
    logic        latch_ff;

    // synchronise the serial pins: {cs_n, sclk, io[3:0]}
    pin_sync #(
        .W       (6),
        .RST_VAL (6'h20)
    ) u_sync (
        .mclk    (mclk),
        .rstn    (rstn),
        .pin_in  ({cs_n_pin, sclk_pin, io_in}),
        .level   (pin_lvl),
        .rise    (pin_rise),
        .fall    (pin_fall)
    );

    // program cycle timer
    prog_timer #(
        .CYCLES  (PROG_CYCLES)
    ) u_timer (
        .mclk    (mclk),
        .rstn    (rstn),
        .start   (prog_start_ff),
        .busy    (tmr_busy),
        .done    (tmr_done)
    );

    // pin events and phase decode
    wire        cs_low    = ~pin_lvl[5];
    wire        cs_rise   = pin_rise[5];
    wire        cs_fall   = pin_fall[5];
    wire        sclk_rise = pin_rise[4] & cs_low;
    wire        sclk_fall = pin_fall[4] & cs_low;
    wire [3:0]  io_lvl    = pin_lvl[3:0];
    wire [5:0]  addr_len  = four_byte_mode ? flash_cmd_pkg::ADDR_BITS_4B
                                           : flash_cmd_pkg::ADDR_BITS_3B;
    wire        quad_ph   = (state_ff == ST_QADDR) || (state_ff == ST_MODE) ||
                            (state_ff == ST_WDUMMY) || (state_ff == ST_WBITS);
    wire [5:0]  step      = quad_ph ? flash_cmd_pkg::QUAD_STEP : flash_cmd_pkg::SERIAL_STEP;
    wire [5:0]  cnt_nxt   = cnt_ff + step;
    wire [31:0] sh_nxt    = quad_ph ? {shift_ff[27:0], io_lvl} : {shift_ff[30:0], io_lvl[0]};
    wire [5:0]  need      = (state_ff == ST_OPCODE) ? flash_cmd_pkg::OPCODE_BITS :
                            (state_ff == ST_MODE)   ? flash_cmd_pkg::MODE_BITS :
                            (state_ff == ST_WBITS)  ? flash_cmd_pkg::WRAP_BITS :
                            (state_ff == ST_PDATA)  ? flash_cmd_pkg::DATA_BITS : addr_len;
    wire        ph_done   = (cnt_nxt == need);
    wire [7:0]  opcode    = sh_nxt[7:0];

    // opcode dispatch; ignored while busy
    wire        is_read   = (opcode == flash_cmd_pkg::OP_OCTAL_WORD_READ) &&
                            quad_io_enable_bit;
    wire        is_wrap   = (opcode == flash_cmd_pkg::OP_SET_WRAP);
    wire        is_prog   = (opcode == flash_cmd_pkg::OP_PAGE_PROGRAM) && latch_ff;
    wire        op_ok     = ~tmr_busy;
    wire        mode_key  = (sh_nxt[flash_cmd_pkg::MODE_KEY_LSB +: 2] ==
                             flash_cmd_pkg::MODE_CONT_KEY);
    wire        commit_ok = (state_ff == ST_PDATA) && (cnt_ff == 6'h00) &&
                            (nbytes_ff != 9'h000) && latch_ff && !page_protected && op_ok;

    // command sequencer
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_ff     <= ST_IDLE;
            cnt_ff       <= 6'h00;
            shift_ff     <= 32'h0000_0000;
            addr_ff      <= 32'h0000_0000;
            nib_ff       <= 1'b0;
            cont_mode_ff <= 1'b0;
            wrap_cfg_ff  <= flash_cmd_pkg::WRAP_CFG_RST;
        end
        else if (soft_reset)
        begin
            state_ff     <= ST_IDLE;
            cont_mode_ff <= 1'b0;
            wrap_cfg_ff  <= flash_cmd_pkg::WRAP_CFG_RST;
        end
        else if (cs_rise)
        begin
            state_ff <= ST_IDLE; // mode and wrap survive
        end
        else if (cs_fall)
        begin
            cnt_ff   <= 6'h00;
            shift_ff <= 32'h0000_0000;
            // skip the opcode while armed
            state_ff <= cont_mode_ff ? ST_QADDR : ST_OPCODE;
        end
        else if (sclk_rise)
        begin
            shift_ff <= sh_nxt;
            cnt_ff   <= ph_done ? 6'h00 : cnt_nxt;
            if (ph_done)
            begin
                case (state_ff)
                    ST_OPCODE:
                    begin
                        shift_ff <= 32'h0000_0000;
                        if (!op_ok)
                            state_ff <= ST_IGNORE;
                        else if (is_read)
                            state_ff <= ST_QADDR;
                        else if (is_wrap)
                            state_ff <= ST_WDUMMY;
                        else if (is_prog)
                            state_ff <= ST_PADDR;
                        else
                            state_ff <= ST_IGNORE;
                    end
                    ST_QADDR:
                    begin
                        addr_ff  <= {sh_nxt[31:4], 4'h0};
                        state_ff <= ST_MODE;
                    end
                    ST_MODE:
                    begin
                        // lower nibble is not looked at
                        cont_mode_ff <= mode_key;
                        nib_ff       <= 1'b0;
                        state_ff     <= ST_RDATA;
                    end
                    ST_WDUMMY:
                    begin
                        state_ff <= ST_WBITS;
                    end
                    ST_WBITS:
                    begin
                        // keep length and disable bits only
                        wrap_cfg_ff <= sh_nxt[flash_cmd_pkg::WRAP_FIELD_LSB +: 3];
                        state_ff    <= ST_IGNORE;
                    end
                    ST_PADDR:
                    begin
                        addr_ff  <= sh_nxt;
                        state_ff <= ST_PDATA;
                    end
                    default:
                    begin
                        state_ff <= state_ff;
                    end
                endcase
            end
        end
        else if (sclk_fall && state_ff == ST_RDATA)
        begin
            nib_ff <= ~nib_ff;
            if (nib_ff)
                addr_ff <= wrap_next(addr_ff, wrap_cfg_ff);
        end
    end

    // read lanes: high then low nibble per sclk fall
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            io_out_ff <= 4'h0;
            io_oe_ff  <= 4'h0;
        end
        else if (cs_rise || soft_reset || state_ff != ST_RDATA)
        begin
            io_oe_ff <= 4'h0;
        end
        else if (sclk_fall)
        begin
            // lanes turn round only once the host has let go
            io_oe_ff  <= 4'hF;
            io_out_ff <= nib_ff ? rd_data[3:0] : rd_data[7:4];
        end
    end

    // program bytes into the page buffer
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            wr_idx_ff   <= 8'h00;
            nbytes_ff   <= 9'h000;
            buf_we_ff   <= 1'b0;
            buf_idx_ff  <= 8'h00;
            buf_data_ff <= 8'h00;
        end
        else
        begin
            buf_we_ff <= 1'b0;
            if (sclk_rise && ph_done && state_ff == ST_PADDR)
            begin
                wr_idx_ff <= sh_nxt[7:0];
                nbytes_ff <= 9'h000;
            end
            else if (sclk_rise && ph_done && state_ff == ST_PDATA)
            begin
                buf_we_ff   <= 1'b1;
                buf_idx_ff  <= wr_idx_ff;
                buf_data_ff <= sh_nxt[7:0];
                wr_idx_ff   <= wr_idx_ff + 8'h01;
                if (nbytes_ff != flash_cmd_pkg::PAGE_BYTES)
                    nbytes_ff <= nbytes_ff + 9'h001;
            end
        end
    end

    // launch the program on a clean frame end
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            prog_start_ff <= 1'b0;
            prog_addr_ff  <= 32'h0000_0000;
        end
        else
        begin
            // a partial byte or a protected page drops the command
            prog_start_ff <= cs_rise && commit_ok && !soft_reset;
            if (cs_rise && commit_ok)
                prog_addr_ff <= {addr_ff[31:8], 8'h00};
        end
    end

    // write enable latch: set beats clear and done
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            latch_ff <= 1'b0;
        else if (latch_set)
            latch_ff <= 1'b1;
        else if (tmr_done || latch_clr)
            latch_ff <= 1'b0;
    end

    // busy follows the self-timed cycle
    logic busy_ff;
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            busy_ff <= 1'b0;
        else
            busy_ff <= prog_start_ff | (tmr_busy & ~tmr_done);
    end

    // outputs
    assign io_out               = io_out_ff;
    assign io_oe                = io_oe_ff;
    assign rd_addr              = addr_ff;
    assign buf_we               = buf_we_ff;
    assign buf_idx              = buf_idx_ff;
    assign buf_data             = buf_data_ff;
    assign prog_addr            = prog_addr_ff;
    assign prog_start           = prog_start_ff;
    assign busy                 = busy_ff;
    assign write_enable_latch   = latch_ff;
    assign wrap_config          = wrap_cfg_ff;
    assign continuous_read_mode = cont_mode_ff;

endmodule : quad_flash_cmd

// [verification/quad_flash_cmd_sva.sv]
/* checker on quad_flash_cmd ports.
   assumes the bind below the module. */
`timescale 1ns/1ps
module quad_flash_cmd_sva #(
    parameter int unsigned PROG_CYCLES = flash_cmd_pkg::PROG_CYCLES
) (
    // clock and reset
    input wire logic        mclk,
    input wire logic        rstn,
    // watched ports
    input wire logic        cs_n_pin,
    input wire logic [3:0]  io_oe,
    input wire logic        soft_reset,
    input wire logic [31:0] prog_addr,
    input wire logic        page_protected,
    input wire logic        prog_start,
    input wire logic        busy,
    input wire logic        write_enable_latch,
    input wire logic [2:0]  wrap_config,
    input wire logic        continuous_read_mode
);
    logic [31:0] busy_cnt_ff;
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rstn);
    // length of the current busy run
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            busy_cnt_ff <= 32'h0;
        else
            busy_cnt_ff <= busy ? busy_cnt_ff + 32'h1 : 32'h0;
    end
    AST_PROG_BUSY: assert property (prog_start |=> busy[*8])
        else $error("no busy after start");
    AST_BUSY_LEN: assert property ($fell(busy) |-> busy_cnt_ff == 32'(PROG_CYCLES) + 32'h1)
        else $error("wrong cycle length");
    AST_WEL_DONE: assert property ($fell(busy) |-> !write_enable_latch)
        else $error("latch kept after cycle");
    AST_PROG_WEL: assert property (prog_start |-> write_enable_latch)
        else $error("start without latch");
    AST_PROG_PROT: assert property (prog_start |-> !page_protected)
        else $error("start on protected page");
    AST_PROG_PAGE: assert property (prog_start |-> prog_addr[7:0] == 8'h00)
        else $error("start not page aligned");
    AST_WRAP_SOFT: assert property (soft_reset |=> wrap_config == 3'h1 && !continuous_read_mode)
        else $error("soft reset kept wrap or mode");
    AST_OE_IDLE: assert property (cs_n_pin[*8] |-> io_oe == 4'h0)
        else $error("lanes driven while deselected");
endmodule : quad_flash_cmd_sva

bind quad_flash_cmd quad_flash_cmd_sva #(.PROG_CYCLES(PROG_CYCLES)) u_sva (
    .mclk(mclk), .rstn(rstn), .cs_n_pin(cs_n_pin), .io_oe(io_oe), .soft_reset(soft_reset),
    .prog_addr(prog_addr), .page_protected(page_protected), .prog_start(prog_start),
    .busy(busy), .write_enable_latch(write_enable_latch), .wrap_config(wrap_config),
    .continuous_read_mode(continuous_read_mode));

// [verification/host_spi_model.sv]
/* host model: frames, lane shifting, read sampling.
   assumes mclk paces it; sclk is 8 mclk, idles low. */
`timescale 1ns/1ps
module host_spi_model (
    // pacing clock
    input  wire logic       mclk,
    // device lane drive
    input  wire logic [3:0] io_out,
    input  wire logic [3:0] io_oe,
    // host pins
    output logic            sclk_pin,
    output logic            cs_n_pin,
    output logic      [3:0] io_in
);
    logic [3:0] lane_val = 4'h0;
    logic       lane_drv = 1'b0;
    // pins idle: deselected, clock low
    initial
    begin
        sclk_pin = 1'b0;
        cs_n_pin = 1'b1;
    end
    // released lanes show the inverse of the last host value
    assign io_in = (io_oe & io_out) | (~io_oe & (lane_drv ? lane_val : ~lane_val));
    // one serial clock: lanes change with the fall, 4 mclk low, 4 high
    task automatic tick(input logic [3:0] v, input logic drv);
        @(posedge mclk);
        sclk_pin <= 1'b0;
        if (drv)
            lane_val <= v;
        lane_drv <= drv;
        repeat (4) @(posedge mclk);
        sclk_pin <= 1'b1;
        repeat (3) @(posedge mclk);
    endtask : tick
    // msb-first shift, one or four lanes per clock
    task automatic shift(input logic [31:0] v, input int n, input logic quad);
        for (int i = n; i > 0; i -= (quad ? 4 : 1))
            tick(quad ? v[i-1 -: 4] : {3'h0, v[i-1]}, 1'b1);
    endtask : shift
    // select held low for the whole frame
    task automatic frame_start();
        @(posedge mclk);
        cs_n_pin <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask : frame_start
    // deselect after the last whole clock, then idle
    task automatic frame_end();
        @(posedge mclk);
        sclk_pin <= 1'b0;
        lane_drv <= 1'b0;
        repeat (2) @(posedge mclk);
        cs_n_pin <= 1'b1;
        repeat (10) @(posedge mclk);
    endtask : frame_end
    // one read byte, nibbles taken late in the high phase
    task automatic rd_byte(output logic [7:0] b);
        tick(4'h0, 1'b0);
        b[7:4] = io_in;
        tick(4'h0, 1'b0);
        b[3:0] = io_in;
    endtask : rd_byte
endmodule : host_spi_model

// [verification/tb_top.sv]
/* testbench for quad_flash_cmd: host frames with expected values.
   assumes host_spi_model and the bound checker. */
`timescale 1ns/1ps
module tb_top;
    logic        mclk = 1'b0;
    logic        rstn = 1'b0;
    logic        quad_io_enable_bit, four_byte_mode, soft_reset, latch_set, latch_clr;
    logic        page_protected;
    logic [7:0]  rd_data;
    wire logic   sclk_pin, cs_n_pin, buf_we, prog_start, busy, write_enable_latch;
    wire logic   continuous_read_mode;
    wire logic [3:0]  io_in, io_out, io_oe;
    wire logic [31:0] rd_addr, prog_addr;
    wire logic [7:0]  buf_idx, buf_data;
    wire logic [2:0]  wrap_config;
    int          fails, num_checks, starts, cycles;
    logic [3:0]  oe_seen;
    logic [15:0] buf_log[$];

    quad_flash_cmd #(.PROG_CYCLES(20)) i_dut (
        .mclk(mclk), .rstn(rstn), .sclk_pin(sclk_pin), .cs_n_pin(cs_n_pin), .io_in(io_in),
        .io_out(io_out), .io_oe(io_oe), .quad_io_enable_bit(quad_io_enable_bit),
        .four_byte_mode(four_byte_mode), .soft_reset(soft_reset), .latch_set(latch_set),
        .latch_clr(latch_clr), .rd_addr(rd_addr), .rd_data(rd_data), .buf_we(buf_we),
        .buf_idx(buf_idx), .buf_data(buf_data), .prog_addr(prog_addr),
        .page_protected(page_protected), .prog_start(prog_start), .busy(busy),
        .write_enable_latch(write_enable_latch), .wrap_config(wrap_config),
        .continuous_read_mode(continuous_read_mode));
    host_spi_model host (.mclk(mclk), .io_out(io_out), .io_oe(io_oe), .sclk_pin(sclk_pin),
        .cs_n_pin(cs_n_pin), .io_in(io_in));

    // clock, array stub, monitors, hang guard
    always #4 mclk = ~mclk;
    always @(posedge mclk)
    begin
        rd_data <= rd_addr[7:0] ^ 8'hA5;
        oe_seen = oe_seen | io_oe;
        if (buf_we === 1'b1)
            buf_log.push_back({buf_idx, buf_data});
        if (prog_start === 1'b1)
            starts++;
        cycles++;
        if (cycles > 40000)
        begin
            fails++;
            wrap_up();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : wrap_up
    // expected read byte k
    function automatic logic [7:0] exp_byte(input logic [31:0] a, input int k,
                                            input logic [2:0] cfg);
        logic [7:0] len;
        logic [7:0] lo;
        len = 8'h08 << cfg[2:1];
        lo = a[7:0] & 8'hF0;
        if (!cfg[0])
            lo = (lo & ~(len - 8'h01)) | ((lo + 8'(k)) & (len - 8'h01));
        else
            lo = lo + 8'(k);
        return lo ^ 8'hA5;
    endfunction : exp_byte
    task automatic latch_pulse(input logic set, input logic clr);
        @(posedge mclk);
        latch_set <= set;
        latch_clr <= clr;
        @(posedge mclk);
        latch_set <= 1'b0;
        latch_clr <= 1'b0;
        @(posedge mclk);
    endtask : latch_pulse
    task automatic wrap_cmd(input logic [7:0] w);
        host.frame_start();
        host.shift(32'h77, 8, 1'b0);
        host.shift(32'h0, four_byte_mode ? 32 : 24, 1'b1);
        host.shift(32'(w), 8, 1'b1);
        host.frame_end();
    endtask : wrap_cmd
    task automatic qread(input logic [31:0] a, input logic [7:0] m, input int nb,
                         input logic op, input logic [2:0] cfg);
        logic [7:0] b;
        host.frame_start();
        if (op)
            host.shift(32'hE3, 8, 1'b0);
        host.shift(a, four_byte_mode ? 32 : 24, 1'b1);
        host.shift(32'(m), 8, 1'b1);
        for (int k = 0; k < nb; k++)
        begin
            host.rd_byte(b);
            check(32'(b), 32'(exp_byte(a, k, cfg)));
        end
        host.frame_end();
    endtask : qread
    task automatic prog(input logic [31:0] a, input int nb, input int extra);
        host.frame_start();
        host.shift(32'h02, 8, 1'b0);
        host.shift(a, 24, 1'b0);
        for (int k = 0; k < nb; k++)
            host.shift(32'(8'h3C + 8'(k)), 8, 1'b0);
        if (extra > 0)
            host.shift(32'h5, extra, 1'b0);
        host.frame_end();
    endtask : prog

    // main sequence
    initial
    begin
        quad_io_enable_bit = 1'b1;
        four_byte_mode = 1'b0;
        soft_reset = 1'b0;
        latch_set = 1'b0;
        latch_clr = 1'b0;
        page_protected = 1'b0;
        oe_seen = 4'h0;
        repeat (6) @(posedge mclk);
        rstn <= 1'b1;
        repeat (3) @(posedge mclk);
        check(32'(wrap_config), 32'h1);
        $display("test reset done");
        for (int n = 0; n < 4; n++)
        begin
            wrap_cmd(8'h8F | 8'(n << 5));
            check(32'(wrap_config), 32'(n << 1));
            qread(32'h37, 8'h00, 9, 1'b1, 3'(n << 1));
        end
        @(posedge mclk);
        soft_reset <= 1'b1;
        @(posedge mclk);
        soft_reset <= 1'b0;
        @(posedge mclk);
        check(32'(wrap_config), 32'h1);
        $display("test wrap lengths done");
        qread(32'h40, 8'h2F, 2, 1'b1, 3'h1);
        check(32'(continuous_read_mode), 32'h1);
        qread(32'h120, 8'h00, 2, 1'b0, 3'h1);
        check(32'(continuous_read_mode), 32'h0);
        qread(32'h80, 8'hA0, 1, 1'b1, 3'h1);
        host.frame_start();
        host.shift(32'hFF, 8, 1'b0);
        host.frame_end();
        check(32'(continuous_read_mode), 32'h0);
        $display("test continuous mode done");
        @(posedge mclk);
        four_byte_mode <= 1'b1;
        wrap_cmd(8'h40);
        check(32'(wrap_config), 32'h4);
        qread(32'h0100003A, 8'h00, 9, 1'b1, 3'h4);
        wrap_cmd(8'h50);
        check(32'(wrap_config), 32'h5);
        qread(32'h0100003A, 8'h00, 9, 1'b1, 3'h5);
        four_byte_mode <= 1'b0;
        quad_io_enable_bit <= 1'b0;
        oe_seen = 4'h0;
        host.frame_start();
        host.shift(32'hE3, 8, 1'b0);
        host.shift(32'h0, 32, 1'b1);
        host.tick(4'h0, 1'b0);
        host.tick(4'h0, 1'b0);
        host.frame_end();
        check(32'(oe_seen), 32'h0);
        quad_io_enable_bit <= 1'b1;
        $display("test four byte and enable done");
        latch_pulse(1'b1, 1'b0);
        check(32'(write_enable_latch), 32'h1);
        starts = 0;
        prog(32'h12FE, 3, 0);
        check(32'(starts), 32'h1);
        check(prog_addr, 32'h1200);
        check(32'(busy), 32'h1);
        check(32'(buf_log.size()), 32'h3);
        for (int k = 0; k < 3; k++)
            check(32'(buf_log[k]), 32'({8'hFE + 8'(k), 8'h3C + 8'(k)}));
        for (int i = 0; i < 200 && busy !== 1'b0; i++)
            @(posedge mclk);
        check(32'(busy), 32'h0);
        check(32'(write_enable_latch), 32'h0);
        for (int r = 0; r < 3; r++)
        begin
            latch_pulse(r > 0, r == 0);
            page_protected <= (r == 2);
            starts = 0;
            prog(32'h500, 2, (r == 1) ? 3 : 0);
            check(32'(starts), 32'h0);
            check(32'(write_enable_latch), 32'(r > 0));
        end
        page_protected <= 1'b0;
        $display("test page program done");
        wrap_up();
    end
endmodule : tb_top
